/* design/sipsc_pkg.sv */
/*
 * constants, state codes and register layout shared by the power-save
 * control block and its helpers.
 * assumes a 20 MHz pclk and a 32-bit apb register bus.
 */
package sipsc_pkg;

	// ----------------------------------------------------------------
	// clock and timing
	// ----------------------------------------------------------------
	localparam int PCLK_HZ        = 20_000_000;  // pclk rate
	localparam int RESUME_MIN_CYC = 2;           // earliest cpu restart after wake
	localparam int RESUME_MAX_CYC = 4;           // latest cpu restart after wake
	localparam int RESUME_CYC     = 3;           // chosen restart delay, inside the window

	// ----------------------------------------------------------------
	// register byte offsets
	// ----------------------------------------------------------------
	localparam logic [7:0] OFS_RESET_CTRL = 8'h00;  // reset_control_register
	localparam logic [7:0] OFS_ENABLES    = 8'h04;  // watchdog / monitor enables
	localparam logic [7:0] OFS_CLK_SEL    = 8'h08;  // system clock source select
	localparam logic [7:0] OFS_MOD_DIS    = 8'h0c;  // peripheral module disable
	localparam logic [7:0] OFS_STOP_IDLE  = 8'h10;  // per-peripheral stop-in-idle
	localparam logic [7:0] OFS_STATUS     = 8'h14;  // power state and wake cause

	// ----------------------------------------------------------------
	// field positions
	// ----------------------------------------------------------------
	localparam int BIT_CORE_KEEP  = 8;   // core_regulator_sleep_keep
	localparam int BIT_FLASH_KEEP = 11;  // flash_regulator_sleep_keep
	localparam int BIT_WDT_EN     = 0;   // watchdog_timer enable
	localparam int BIT_FAIL_SAFE_CLOCK_MONITOR_EN    = 1;   // fail_safe_clock_monitor enable
	localparam int CLK_SEL_W      = 3;   // clock source select width
	localparam int BIT_ST_SLEEP   = 0;   // status: in sleep
	localparam int BIT_ST_IDLE    = 1;   // status: in idle
	localparam int BIT_ST_CAUSE   = 4;   // status: wake cause, 3 bits

	// ----------------------------------------------------------------
	// reset values
	// ----------------------------------------------------------------
	localparam logic [31:0] RST_RESET_CTRL = 32'h0000_0000;
	localparam logic [31:0] RST_ENABLES    = 32'h0000_0000;
	localparam logic [31:0] RST_CLK_SEL    = 32'h0000_0000;
	localparam logic [31:0] RST_MOD_DIS    = 32'h0000_0000;
	localparam logic [31:0] RST_STOP_IDLE  = 32'h0000_0000;

	// ----------------------------------------------------------------
	// power-save instruction operand and states
	// ----------------------------------------------------------------
	localparam logic MODE_SLEEP = 1'b0;  // operand value selecting sleep
	localparam logic MODE_IDLE  = 1'b1;  // operand value selecting idle

	typedef enum logic [4:0] {
		ST_RUN   = 5'h01,
		ST_ENTER = 5'h02,
		ST_SLEEP = 5'h04,
		ST_IDLE  = 5'h08,
		ST_WAKE  = 5'h10
	} sipsc_state_e;

endpackage : sipsc_pkg

/* design/sipsc_wake_latch.sv */
/*
 * wake event catcher: holds interrupt, reset and watchdog events seen
 * from the power-save instruction onward until the block consumes them.
 * assumes event inputs synchronous to pclk.
 */
`timescale 1ns/1ns
module sipsc_wake_latch
	import sipsc_pkg::*;
(
	// clock and reset
	input  wire logic       pclk,
	input  wire logic       presetn,
	// control
	input  wire logic       arm,
	input  wire logic       consume,
	// events
	input  wire logic       irq,
	input  wire logic       reset_event,
	input  wire logic       wdt_timeout,
	// result
	output logic            wake,
	output logic      [2:0] cause
);

	// ----------------------------------------------------------------
	// event capture
	// ----------------------------------------------------------------
	logic [2:0] hit;          // raw events this cycle
	logic [2:0] held;         // events caught while armed
	logic       armed;        // catching window open

	assign hit  = {wdt_timeout, reset_event, irq};
	assign wake = armed && ((held | hit) != 3'h0);

	// window opens at the instruction, closes when consumed
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			armed <= 1'b0;
			held  <= 3'h0;
			cause <= 3'h0;
		end else begin
			if (consume) begin
				armed <= 1'b0;
				held  <= 3'h0;
				cause <= held | hit;
			end else if (arm || armed) begin
				armed <= 1'b1;
				held  <= held | hit;  // coincident events are kept [R16]
			end
		end
	end

endmodule : sipsc_wake_latch

/* design/sipsc_resume_timer.sv */
/*
 * resume delay counter: after a wake, counts the cycles before the cpu
 * clock and execution are released.
 * assumes a one-cycle start pulse.
 */
`timescale 1ns/1ns
module sipsc_resume_timer
	import sipsc_pkg::*;
#(
	parameter int CYCLES = RESUME_CYC
)(
	// clock and reset
	input  wire logic pclk,
	input  wire logic presetn,
	// control
	input  wire logic start,
	output logic      done
);

	// ----------------------------------------------------------------
	// counter
	// ----------------------------------------------------------------
	logic [3:0] count;  // cycles left
	logic       busy;   // counting

	assign done = busy && (count == 4'h1);

	// load on start, count down to release
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			count <= 4'h0;
			busy  <= 1'b0;
		end else if (start) begin
			count <= 4'(CYCLES);  // [R14]
			busy  <= 1'b1;
		end else if (busy) begin
			count <= count - 4'h1;
			busy  <= (count != 4'h1);
		end
	end

endmodule : sipsc_resume_timer

/* design/sipsc_power_ctrl.sv */
/*
 * sleep and idle power-save controller with its apb register file.
 * assumes the core raises a one-cycle power-save request with a mode
 * operand, and that interrupt, reset and watchdog events are already
 * qualified and synchronous to pclk.
 */
// The APB interface to the registers and the address map were decided locally.
`timescale 1ns/1ns
// Summary of operation
// [R1] sleep stops system clock and its oscillator
// [R2] clock monitor inactive during sleep
// [R3] rc oscillator runs in sleep if watchdog on
// [R4] watchdog cleared just before sleep entry
// [R5] sleep disables system-clocked peripherals
// [R6] interrupt, reset or timeout wakes from sleep
// [R7] resume on clock source chosen at entry
// [R8] bits 8, 11 keep regulators awake
// [R9] idle stops cpu, system clock keeps running
// [R10] watchdog cleared on idle entry
// [R11] idle peripherals run unless module disabled
// [R12] rc oscillator in idle if watchdog/monitor on
// [R13] interrupt, reset or timeout wakes from idle
// [R14] cpu resumes two to four cycles later
// [R15] per-peripheral stop-in-idle control bits
// [R16] coincident interrupt deferred, then wakes immediately
// [R17] core passes sleep/idle choice as operand
module sipsc_power_ctrl
	import sipsc_pkg::*;
#(
	parameter int NPERIPH = 8
)(
	// clock and reset
	input  wire logic                 pclk,
	input  wire logic                 presetn,
	// apb slave
	input  wire logic                 psel,
	input  wire logic                 penable,
	input  wire logic                 pwrite,
	input  wire logic [7:0]           paddr,
	input  wire logic [31:0]          pwdata,
	output logic      [31:0]          prdata,
	output logic                      pready,
	output logic                      pslverr,
	// core power-save instruction
	input  wire logic                 power_save_instruction,
	input  wire logic                 power_save_mode,
	// wake sources
	input  wire logic                 irq_enabled_pending,
	input  wire logic                 reset_event,
	input  wire logic                 watchdog_timeout,
	// cpu and clock control
	output logic                      cpu_clk_en,
	output logic                      resume,
	output logic                      sys_clk_en,
	output logic                      sys_osc_en,
	output logic      [CLK_SEL_W-1:0] clk_src_sel,
	output logic                      fail_safe_monitor_en,
	output logic                      low_power_rc_en,
	output logic                      watchdog_clear,
	// regulators
	output logic                      core_reg_standby,
	output logic                      flash_reg_standby,
	// peripherals
	output logic      [NPERIPH-1:0]   periph_clk_en
);

	// ----------------------------------------------------------------
	// registers
	// ----------------------------------------------------------------
	logic [31:0]          reset_control_register;  // regulator keep bits
	logic [1:0]           enables;                 // watchdog, monitor
	logic [CLK_SEL_W-1:0] clk_sel;                 // software clock choice
	logic [CLK_SEL_W-1:0] entry_clk;               // source frozen at entry
	logic [NPERIPH-1:0]   mod_disable;             // module disable bits
	logic [NPERIPH-1:0]   stop_in_idle;            // stop-in-idle bits
	logic                 mode_idle;               // latched operand
	sipsc_state_e         state;                   // power state
	sipsc_state_e         next_state;              // next power state

	// ----------------------------------------------------------------
	// apb decode
	// ----------------------------------------------------------------
	wire        setup    = psel && !penable;        // first cycle
	wire        access   = psel && penable;         // second cycle
	wire        wr_en    = access && pwrite;        // write strobe
	wire        hit_rst  = (paddr == OFS_RESET_CTRL);
	wire        hit_en   = (paddr == OFS_ENABLES);
	wire        hit_clk  = (paddr == OFS_CLK_SEL);
	wire        hit_dis  = (paddr == OFS_MOD_DIS);
	wire        hit_sidl = (paddr == OFS_STOP_IDLE);
	wire        hit_stat = (paddr == OFS_STATUS);
	wire        mapped   = hit_rst | hit_en | hit_clk | hit_dis | hit_sidl | hit_stat;
	wire        wdt_on   = enables[BIT_WDT_EN];
	wire        fail_safe_clock_monitor_on  = enables[BIT_FAIL_SAFE_CLOCK_MONITOR_EN];
	wire [2:0]  wake_cause;
	wire        wake;
	wire        resume_done;
	wire        in_sleep = (state == ST_SLEEP);
	wire        in_idle  = (state == ST_IDLE);

	// only the writable bits of the reset control register
	localparam logic [31:0] RESET_CONTROL_REGISTER_MASK = (32'h1 << BIT_CORE_KEEP) | (32'h1 << BIT_FLASH_KEEP);

	// zero-extends a peripheral bit vector to a bus word
	function automatic logic [31:0] widen(input logic [NPERIPH-1:0] v);
		widen = 32'h0;
		widen[NPERIPH-1:0] = v;
	endfunction : widen

	// read mux
	wire [31:0] status_word = {25'h0, wake_cause, 2'h0, in_idle, in_sleep};
	wire [31:0] rd_word =
		hit_rst  ? reset_control_register :
		hit_en   ? {30'h0, enables} :
		hit_clk  ? {{(32-CLK_SEL_W){1'b0}}, clk_sel} :
		hit_dis  ? widen(mod_disable) :
		hit_sidl ? widen(stop_in_idle) :
		hit_stat ? status_word : 32'h0;

	// always ready; unmapped addresses flag an error in the access cycle
	assign pready  = 1'b1;
	assign pslverr = access && !mapped;

	// read data captured during setup, stable through access
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= 32'h0;
		end else if (setup && !pwrite) begin
			prdata <= rd_word;
		end
	end

	// software writable registers
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			reset_control_register <= RST_RESET_CTRL;
			enables                <= RST_ENABLES[1:0];
			clk_sel                <= RST_CLK_SEL[CLK_SEL_W-1:0];
			mod_disable            <= RST_MOD_DIS[NPERIPH-1:0];
			stop_in_idle           <= RST_STOP_IDLE[NPERIPH-1:0];
		end else if (wr_en) begin
			if (hit_rst)
				reset_control_register <= pwdata & RESET_CONTROL_REGISTER_MASK;  // [R8]
			if (hit_en)
				enables <= pwdata[1:0];
			if (hit_clk)
				clk_sel <= pwdata[CLK_SEL_W-1:0];
			if (hit_dis)
				mod_disable <= pwdata[NPERIPH-1:0];  // [R11]
			if (hit_sidl)
				stop_in_idle <= pwdata[NPERIPH-1:0];  // [R15]
		end
	end

	// ----------------------------------------------------------------
	// wake event capture and resume delay
	// ----------------------------------------------------------------
	wire enter_req = (state == ST_RUN) && power_save_instruction;

	sipsc_wake_latch u_wake (
		.pclk        (pclk),
		.presetn     (presetn),
		.arm         (enter_req),
		.consume     ((in_sleep || in_idle) && wake),
		.irq         (irq_enabled_pending),
		.reset_event (reset_event),
		.wdt_timeout (watchdog_timeout),
		.wake        (wake),
		.cause       (wake_cause)
	);

	sipsc_resume_timer #(
		.CYCLES (RESUME_CYC)
	) u_resume (
		.pclk    (pclk),
		.presetn (presetn),
		.start   ((in_sleep || in_idle) && wake),
		.done    (resume_done)
	);

	// ----------------------------------------------------------------
	// power state machine
	// ----------------------------------------------------------------
	always_comb begin
		next_state = state;
		case (state)
			ST_RUN: begin
				if (power_save_instruction)
					next_state = ST_ENTER;  // [R17]
			end
			ST_ENTER: begin
				// entry always completes before any wake is honoured
				next_state = mode_idle ? ST_IDLE : ST_SLEEP;  // [R16]
			end
			ST_SLEEP: begin
				if (wake)
					next_state = ST_WAKE;  // [R6]
			end
			ST_IDLE: begin
				if (wake)
					next_state = ST_WAKE;  // [R13]
			end
			ST_WAKE: begin
				if (resume_done)
					next_state = ST_RUN;  // [R14]
			end
			default: begin
				next_state = ST_RUN;
			end
		endcase
	end

	// state, operand and entry clock source
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state     <= ST_RUN;
			mode_idle <= 1'b0;
			entry_clk <= RST_CLK_SEL[CLK_SEL_W-1:0];
		end else begin
			state <= next_state;
			if (enter_req) begin
				mode_idle <= (power_save_mode == MODE_IDLE);  // [R17]
				entry_clk <= clk_sel;  // [R7]
			end
		end
	end

	// ----------------------------------------------------------------
	// clock, watchdog and regulator outputs
	// ----------------------------------------------------------------
	wire asleep = in_sleep || (state == ST_WAKE && !mode_idle);

	// cpu halted from entry until the resume delay runs out
	assign cpu_clk_en = (state == ST_RUN);  // [R9]
	assign resume     = resume_done;  // [R14]

	// system clock and its oscillator stop only in sleep
	assign sys_clk_en = !asleep;  // [R1]
	assign sys_osc_en = !asleep;  // [R1]

	// held at the entry choice until running again
	assign clk_src_sel = (state == ST_RUN) ? clk_sel : entry_clk;  // [R7]

	// monitor has nothing to watch while the clock is stopped
	assign fail_safe_monitor_en = fail_safe_clock_monitor_on && !asleep;  // [R2]

	// rc oscillator keeps the watchdog, and in idle the monitor, alive
	assign low_power_rc_en = wdt_on || (fail_safe_clock_monitor_on && !asleep);  // [R3] [R12]

	// clear pulse in the entry cycle, before sleep or idle begins
	assign watchdog_clear = wdt_on && (state == ST_ENTER);  // [R4] [R10]

	// regulators stand by in sleep unless the keep bit is set
	assign core_reg_standby  = asleep && !reset_control_register[BIT_CORE_KEEP];  // [R8]
	assign flash_reg_standby = asleep && !reset_control_register[BIT_FLASH_KEEP];  // [R8]

	// ----------------------------------------------------------------
	// peripheral clock gating
	// ----------------------------------------------------------------
	genvar g;
	generate
		for (g = 0; g < NPERIPH; g++) begin : g_periph
			// sleep stops all; idle stops only flagged ones
			assign periph_clk_en[g] = !mod_disable[g] && !asleep  // [R5] [R11]
				&& !((in_idle || state == ST_WAKE) && mode_idle && stop_in_idle[g]);  // [R15]
		end
	endgenerate

endmodule : sipsc_power_ctrl

/* testbench/sipsc_power_ctrl_sva.sv */
/* concurrent checks on the power-save controller ports.
   assumes it is bound onto sipsc_power_ctrl and sees only its ports. */
`timescale 1ns/1ns
module sipsc_power_ctrl_sva
	import sipsc_pkg::*;
#(
	parameter int NPERIPH = 8
)(
	// clock and reset
	input wire logic                 pclk,
	input wire logic                 presetn,
	// core and wake sources
	input wire logic                 power_save_instruction,
	input wire logic                 power_save_mode,
	input wire logic                 irq_enabled_pending,
	input wire logic                 reset_event,
	input wire logic                 watchdog_timeout,
	// clock and power outputs
	input wire logic                 cpu_clk_en,
	input wire logic                 resume,
	input wire logic                 sys_clk_en,
	input wire logic                 sys_osc_en,
	input wire logic [CLK_SEL_W-1:0] clk_src_sel,
	input wire logic                 fail_safe_monitor_en,
	input wire logic                 low_power_rc_en,
	input wire logic                 watchdog_clear,
	input wire logic                 core_reg_standby,
	input wire logic                 flash_reg_standby,
	input wire logic [NPERIPH-1:0]   periph_clk_en
);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	// accepted instruction followed by the entry cycle
	sequence ent_s(m);
		power_save_instruction && cpu_clk_en && power_save_mode == m ##1 !cpu_clk_en;
	endsequence
	sleep_clk_off_a: assert property (ent_s(MODE_SLEEP) |=> !sys_clk_en && !sys_osc_en)
		else $error("system clock running in sleep");
	sleep_mon_off_a: assert property (ent_s(MODE_SLEEP) |=> !fail_safe_monitor_en)
		else $error("clock monitor active in sleep");
	sleep_rc_a: assert property (ent_s(MODE_SLEEP) |=> low_power_rc_en == $past(watchdog_clear))
		else $error("rc oscillator wrong in sleep");
	clear_once_a: assert property (watchdog_clear |-> !cpu_clk_en && $past(power_save_instruction) ##1 !watchdog_clear)
		else $error("watchdog clear outside entry");
	sleep_periph_a: assert property (ent_s(MODE_SLEEP) |=> periph_clk_en == '0)
		else $error("peripheral clock in sleep");
	wake_resume_a: assert property (!cpu_clk_en && (irq_enabled_pending || reset_event || watchdog_timeout)
		|-> ##[0:4] resume)
		else $error("no resume after wake event");
	src_hold_a: assert property (!cpu_clk_en |-> $stable(clk_src_sel))
		else $error("clock source changed while stopped");
	reg_standby_a: assert property (core_reg_standby || flash_reg_standby |-> !sys_clk_en && !cpu_clk_en)
		else $error("regulator standby outside sleep");
	idle_clk_on_a: assert property (ent_s(MODE_IDLE) |=> sys_clk_en && sys_osc_en && !cpu_clk_en)
		else $error("system clock stopped in idle");
	idle_rc_a: assert property (ent_s(MODE_IDLE) |=> low_power_rc_en == ($past(watchdog_clear) || fail_safe_monitor_en))
		else $error("rc oscillator wrong in idle");
	resume_run_a: assert property (resume |=> cpu_clk_en)
		else $error("cpu not running after resume");
	run_after_resume_a: assert property ($rose(cpu_clk_en) |-> $past(resume))
		else $error("cpu restarted without resume");
	defer_wake_a: assert property (power_save_instruction && cpu_clk_en && irq_enabled_pending
		|=> !cpu_clk_en [*5] ##1 cpu_clk_en)
		else $error("coincident interrupt not deferred");
endmodule : sipsc_power_ctrl_sva

bind sipsc_power_ctrl sipsc_power_ctrl_sva #(.NPERIPH(NPERIPH)) u_sva (.pclk, .presetn, .power_save_instruction,
	.power_save_mode, .irq_enabled_pending, .reset_event, .watchdog_timeout, .cpu_clk_en, .resume, .sys_clk_en,
	.sys_osc_en, .clk_src_sel, .fail_safe_monitor_en, .low_power_rc_en, .watchdog_clear, .core_reg_standby,
	.flash_reg_standby, .periph_clk_en);

/* testbench/sipsc_core_model.sv */
/* processor core model: issues the power-save instruction on request.
   assumes go is a one-cycle request from the bench on pclk. */
`timescale 1ns/1ns
module sipsc_core_model (
	// clock, reset and request
	input wire logic pclk,
	input wire logic presetn,
	input wire logic go,
	input wire logic mode,
	input wire logic cpu_clk_en,
	// instruction to the controller
	output logic     power_save_instruction,
	output logic     power_save_mode
);
	// a stopped core cannot execute, and the operand toggles while not valid
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			power_save_instruction <= 1'b0;
			power_save_mode        <= 1'b1;
		end else begin
			power_save_instruction <= go && cpu_clk_en;
			power_save_mode        <= go ? mode : !power_save_mode;
		end
	end
endmodule : sipsc_core_model

/* testbench/testbench.sv */
/* self-checking bench for the power-save controller.
   assumes the core model beside it and the bound checker. */
`timescale 1ns/1ns
module testbench;
	import sipsc_pkg::*;
	logic                 pclk, presetn, psel, penable, pwrite, pready, pslverr, err, go, mode;
	logic [7:0]           paddr, periph_clk_en;
	logic [31:0]          pwdata, prdata, rd;
	logic [2:0]           ev;  // irq, reset event, watchdog time-out
	logic                 power_save_instruction, power_save_mode, cpu_clk_en, resume, sys_clk_en, sys_osc_en;
	logic                 fail_safe_monitor_en, low_power_rc_en, watchdog_clear, wclr;
	logic                 core_reg_standby, flash_reg_standby;
	logic [CLK_SEL_W-1:0] clk_src_sel;
	int                   fail_count, checked;

	sipsc_core_model u_core (.pclk, .presetn, .go, .mode, .cpu_clk_en, .power_save_instruction, .power_save_mode);
	sipsc_power_ctrl #(.NPERIPH(8)) dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
		.pready, .pslverr, .power_save_instruction, .power_save_mode, .irq_enabled_pending(ev[0]),
		.reset_event(ev[1]), .watchdog_timeout(ev[2]), .cpu_clk_en, .resume, .sys_clk_en, .sys_osc_en,
		.clk_src_sel, .fail_safe_monitor_en, .low_power_rc_en, .watchdog_clear, .core_reg_standby,
		.flash_reg_standby, .periph_clk_en);

	// 20 MHz clock
	initial begin
		pclk = 1'b0;
		forever #25 pclk = ~pclk;
	end

	task chk(input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp) begin
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
			fail_count++;
		end
	endtask : chk

	task end_sim;
		$display("checked=%0d fail_count=%0d", checked, fail_count);
		if (fail_count == 0 && checked > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask : end_sim

	// one apb transfer, held until pready is sampled high
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int k;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		k = 0;
		do begin
			@(posedge pclk);
			k++;
		end while (pready !== 1'b1 && k < 8);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (pready !== 1'b1) begin
			fail_count++;
			end_sim();
		end
	endtask : apb

	// instruction, entry cycle (clear seen), then settled in sleep or idle
	task enter(input logic m);
		@(posedge pclk);
		go <= 1'b1;
		mode <= m;
		@(posedge pclk);
		go <= 1'b0;
		@(posedge pclk);
		#1 wclr = watchdog_clear;
		@(posedge pclk);
		#1;
	endtask : enter

	// one wake event, counting cycles up to the resume pulse
	task wake(input int i, output int n);
		@(posedge pclk);
		ev[i] <= 1'b1;
		n = 0;
		do begin
			@(posedge pclk);
			ev <= 3'h0;
			#1 n++;
		end while (resume !== 1'b1 && n < 10);
		if (resume !== 1'b1) begin
			fail_count++;
			end_sim();
		end
		@(posedge pclk);
		#1 chk(cpu_clk_en & sys_clk_en, 1);
	endtask : wake

	task s_regs;
		for (int a = 0; a < 6; a++) begin
			apb(1'b0, 8'(a * 4), 32'h0);
			chk(rd, 32'h0);
		end
		apb(1'b1, OFS_RESET_CTRL, 32'hffff_ffff);
		apb(1'b0, OFS_RESET_CTRL, 32'h0);
		chk(rd, 32'h0000_0900);
		apb(1'b1, 8'h18, 32'hffff_ffff);
		apb(1'b0, 8'h18, 32'h0);
		chk({rd[30:0], err}, 32'h1);
	endtask : s_regs

	// each wake source, keep bits on once, watchdog off once
	task s_sleep;
		int n;
		for (int i = 0; i < 3; i++) begin
			apb(1'b1, OFS_RESET_CTRL, i == 1 ? 32'h900 : 32'h0);
			apb(1'b1, OFS_ENABLES, i == 2 ? 32'h2 : 32'h3);
			apb(1'b1, OFS_CLK_SEL, 32'(i + 5));
			enter(MODE_SLEEP);
			chk(wclr, i != 2);
			chk(sys_clk_en | sys_osc_en, 0);
			chk(fail_safe_monitor_en, 0);
			chk(low_power_rc_en, i != 2);
			chk(periph_clk_en, 0);
			chk({core_reg_standby, flash_reg_standby}, i == 1 ? 0 : 3);
			apb(1'b1, OFS_CLK_SEL, 32'h0);
			apb(1'b0, OFS_STATUS, 32'h0);
			chk(rd & 32'h3, 32'h1);
			chk(clk_src_sel, i + 5);
			wake(i, n);
			chk(n, RESUME_CYC);
			apb(1'b0, OFS_STATUS, 32'h0);
			chk(rd, 32'h1 << (4 + i));
		end
	endtask : s_sleep

	// enables none, watchdog, monitor; one peripheral disabled, one stopped in idle
	task s_idle;
		int n;
		apb(1'b1, OFS_MOD_DIS, 32'h1);
		apb(1'b1, OFS_STOP_IDLE, 32'h2);
		for (int j = 0; j < 3; j++) begin
			apb(1'b1, OFS_ENABLES, 32'(j));
			@(posedge pclk);
			#1 chk(periph_clk_en, 8'hfe);
			enter(MODE_IDLE);
			chk(wclr, j == 1);
			chk({cpu_clk_en, sys_clk_en, sys_osc_en}, 3);
			chk(periph_clk_en, 8'hfc);
			chk(low_power_rc_en, j != 0);
			wake(j, n);
			chk(n, RESUME_CYC);
		end
	endtask : s_idle

	// interrupt in the instruction cycle itself
	task s_defer;
		int n;
		@(posedge pclk);
		go <= 1'b1;
		mode <= MODE_SLEEP;
		@(posedge pclk);
		go <= 1'b0;
		ev[0] <= 1'b1;
		n = 0;
		do begin
			@(posedge pclk);
			ev <= 3'h0;
			#1 n++;
		end while (cpu_clk_en !== 1'b1 && n < 12);
		chk(n, RESUME_CYC + 3);
	endtask : s_defer

	initial begin
		presetn = 1'b0;
		{psel, penable, pwrite, go, mode} = 5'h00;
		paddr = 8'h00;
		pwdata = 32'h0;
		ev = 3'h0;
		fail_count = 0;
		checked = 0;
		repeat (6) @(posedge pclk);
		presetn <= 1'b1;
		s_regs();
		s_sleep();
		s_idle();
		s_defer();
		end_sim();
	end
endmodule : testbench
